// File: hw/tpp_regs.vh
`ifndef TPP_REGS_VH
`define TPP_REGS_VH
// instruction codes
`define TPP_IR_W            4
`define TPP_IR_RESET_CHAIN  4'hC
`define TPP_IR_UNLOCK       4'h4
`define TPP_IR_COMMAND      4'h5
`define TPP_IR_PAGE_FILL    4'h6
`define TPP_IR_PAGE_FETCH   4'h7
`define TPP_IR_BYPASS       4'hF
// register widths and key
`define TPP_UNLOCK_W        16
`define TPP_CMD_W           15
`define TPP_BYTE_W          8
`define TPP_UNLOCK_KEY      16'hA370
`define TPP_UNLOCK_RST      16'h0000
`define TPP_CMD_RST         15'h0000
// timing
`define TPP_CLK_NS          5
`define TPP_FILL_TCK        11
`define TPP_DISABLE_CLR_CLKS 2
`define TPP_FIFO_DEPTH      16
`define TPP_FIFO_AW         4
`endif

// File: hw/tpp_fifo.v
`timescale 1ns/1ps
`default_nettype none
module tpp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // clock and reset
    input  wire             clk,
    input  wire             rstn,
    // write side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // read side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_reg;
    reg [AW:0]      rd_ptr_reg;
    wire            full;
    wire            empty;

    // pointer compare for full and empty
    assign empty     = (wr_ptr_reg == rd_ptr_reg);
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                       (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // storage
    always @(posedge clk)
    begin
        if (in_valid && !full)
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end

    // pointers
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end
        else
        begin
            if (in_valid && !full)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (out_ready && !empty)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: hw/tpp_top.v
// How it works
// - four-bit instruction register, sixteen codes
// - every shift register moves LSB first
// - code 0xC selects one-bit reset chain
// - chain one holds reset, unlatched output
// - chain acts as reset pin low
// - code 0x4 selects sixteen-bit unlock register
// - update-DR compares key, exact match unlocks
// - unlock register clears on power-on reset
// - code 0x5 selects fifteen-bit command register
// - capture loads result, shift exchanges it
// - update presents command, idle clocks once
// - code 0x6 selects low command byte
// - fill update copies byte, writes soon
// - fill updates alternate, low byte first
// - counter steps before low, not first
// - code 0x7 captures bytes, low first
// - counter steps after every high read
// - port works only when enabled, undisabled
// - reset low clears disable bit quickly
`timescale 1ns/1ps
`default_nettype none
`include "tpp_regs.vh"
module tpp_top (
    // clock and reset
    input  wire        CLK,
    input  wire        RSTN,
    // test port pins
    input  wire        TCK,
    input  wire        TMS,
    input  wire        TDI,
    output reg         TDO,
    output reg         TDO_OE,
    // device control
    input  wire        EXT_RESETN,
    input  wire        ENABLE_FUSE,
    input  wire        DISABLE_SET,
    output wire        DISABLE_BIT,
    output wire        CORE_RESET,
    output reg         PROG_MODE,
    // memory interface
    output reg  [14:0] MEM_CMD,
    output reg         MEM_CMD_VALID,
    output reg         MEM_EXEC,
    input  wire [14:0] MEM_RESULT,
    input  wire [15:0] MEM_RDATA,
    output reg  [15:0] PC,
    // page buffer write stream
    output wire        PAGE_VALID,
    input  wire        PAGE_READY,
    output wire [8:0]  PAGE_DATA,
    output wire [15:0] PAGE_ADDR
);
    localparam S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
    localparam S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7;
    localparam S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB;
    localparam S_EX1_IR = 4'hC, S_PA_IR = 4'hD, S_EX2_IR = 4'hE, S_UP_IR = 4'hF;

    reg  [2:0]  tck_sync_reg;
    reg         tms_s1_reg, tms_s2_reg, tdi_s1_reg, tdi_s2_reg;
    reg         rst_s1_reg, rst_s2_reg, ena_s1_reg, ena_s2_reg;
    reg  [3:0]  state_reg;
    reg  [3:0]  state_next;
    reg  [3:0]  ir_shift_reg;
    reg  [3:0]  ir_reg;
    reg         reset_chain_reg;
    reg  [15:0] unlock_reg;
    reg  [14:0] cmd_reg;
    reg         bypass_reg;
    reg         high_byte_reg;
    reg         first_reg;
    reg         disable_reg;
    reg  [1:0]  dis_cnt_reg;
    reg  [3:0]  fill_cnt_reg;
    reg         fill_go_reg;
    reg  [8:0]  hold_reg;
    reg  [15:0] hold_addr_reg;
    wire        tck_rise, tck_fall, port_ok, fifo_ready;

    // pin synchronisers, TCK edge detect on second and third stages
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            tck_sync_reg <= 3'h0;
            tms_s1_reg   <= 1'b1;
            tms_s2_reg   <= 1'b1;
            tdi_s1_reg   <= 1'b0;
            tdi_s2_reg   <= 1'b0;
            rst_s1_reg   <= 1'b1;
            rst_s2_reg   <= 1'b1;
            ena_s1_reg   <= 1'b0;
            ena_s2_reg   <= 1'b0;
        end
        else
        begin
            tck_sync_reg <= {tck_sync_reg[1:0], TCK};
            tms_s1_reg   <= TMS;
            tms_s2_reg   <= tms_s1_reg;
            tdi_s1_reg   <= TDI;
            tdi_s2_reg   <= tdi_s1_reg;
            rst_s1_reg   <= EXT_RESETN;
            rst_s2_reg   <= rst_s1_reg;
            ena_s1_reg   <= ENABLE_FUSE;
            ena_s2_reg   <= ena_s1_reg;
        end
    end
    assign tck_rise = tck_sync_reg[1] && !tck_sync_reg[2];
    assign tck_fall = !tck_sync_reg[1] && tck_sync_reg[2];
    assign port_ok  = ena_s2_reg && !disable_reg;

    // tap next state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            S_RESET:  state_next = tms_s2_reg ? S_RESET  : S_IDLE;
            S_IDLE:   state_next = tms_s2_reg ? S_SEL_DR : S_IDLE;
            S_SEL_DR: state_next = tms_s2_reg ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: state_next = tms_s2_reg ? S_EX1_DR : S_SH_DR;
            S_SH_DR:  state_next = tms_s2_reg ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: state_next = tms_s2_reg ? S_UP_DR  : S_PA_DR;
            S_PA_DR:  state_next = tms_s2_reg ? S_EX2_DR : S_PA_DR;
            S_EX2_DR: state_next = tms_s2_reg ? S_UP_DR  : S_SH_DR;
            S_UP_DR:  state_next = tms_s2_reg ? S_SEL_DR : S_IDLE;
            S_SEL_IR: state_next = tms_s2_reg ? S_RESET  : S_CAP_IR;
            S_CAP_IR: state_next = tms_s2_reg ? S_EX1_IR : S_SH_IR;
            S_SH_IR:  state_next = tms_s2_reg ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: state_next = tms_s2_reg ? S_UP_IR  : S_PA_IR;
            S_PA_IR:  state_next = tms_s2_reg ? S_EX2_IR : S_PA_IR;
            S_EX2_IR: state_next = tms_s2_reg ? S_UP_IR  : S_SH_IR;
            default:  state_next = tms_s2_reg ? S_SEL_DR : S_IDLE;
        endcase
    end

    // tap state, instruction and data registers on TCK rise; state forced to reset on any clock while port_ok is low
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_reg       <= S_RESET;
            ir_shift_reg    <= 4'h0;
            ir_reg          <= `TPP_IR_BYPASS;
            reset_chain_reg <= 1'b0;
            unlock_reg      <= `TPP_UNLOCK_RST;
            cmd_reg         <= `TPP_CMD_RST;
            bypass_reg      <= 1'b0;
            high_byte_reg   <= 1'b0;
            first_reg       <= 1'b1;
            PROG_MODE       <= 1'b0;
            MEM_CMD         <= 15'h0000;
            MEM_CMD_VALID   <= 1'b0;
            MEM_EXEC        <= 1'b0;
            PC              <= 16'h0000;
            fill_go_reg     <= 1'b0;
            hold_reg        <= 9'h000;
            hold_addr_reg   <= 16'h0000;
        end
        else
        begin
            MEM_EXEC      <= 1'b0;
            MEM_CMD_VALID <= 1'b0;
            fill_go_reg   <= 1'b0;
            if (!port_ok)
                state_reg <= S_RESET;
            else if (tck_rise)
            begin
                state_reg <= state_next;
                case (state_reg)
                    S_RESET:
                    begin
                        ir_reg <= `TPP_IR_BYPASS;
                    end
                    S_CAP_IR:
                    begin
                        ir_shift_reg <= 4'h1;
                    end
                    S_SH_IR:
                    begin
                        ir_shift_reg <= {tdi_s2_reg, ir_shift_reg[3:1]};
                    end
                    S_UP_IR:
                    begin
                        ir_reg        <= ir_shift_reg;
                        high_byte_reg <= 1'b0;
                        first_reg     <= 1'b1;
                    end
                    S_CAP_DR:
                    begin
                        bypass_reg <= 1'b0;
                        if (ir_reg == `TPP_IR_COMMAND)
                            cmd_reg <= MEM_RESULT;
                        else if (ir_reg == `TPP_IR_PAGE_FETCH)
                        begin
                            cmd_reg[7:0]  <= high_byte_reg ? MEM_RDATA[15:8] : MEM_RDATA[7:0];
                            high_byte_reg <= !high_byte_reg;
                            if (high_byte_reg)
                                PC <= PC + 16'h0001;
                        end
                    end
                    S_SH_DR:
                    begin
                        if (ir_reg == `TPP_IR_RESET_CHAIN)
                            reset_chain_reg <= tdi_s2_reg;
                        else if (ir_reg == `TPP_IR_UNLOCK)
                            unlock_reg <= {tdi_s2_reg, unlock_reg[15:1]};
                        else if (ir_reg == `TPP_IR_COMMAND)
                            cmd_reg <= {tdi_s2_reg, cmd_reg[14:1]};
                        else if (ir_reg == `TPP_IR_PAGE_FILL || ir_reg == `TPP_IR_PAGE_FETCH)
                            cmd_reg[7:0] <= {tdi_s2_reg, cmd_reg[7:1]};
                        else
                            bypass_reg <= tdi_s2_reg;
                    end
                    S_UP_DR:
                    begin
                        if (ir_reg == `TPP_IR_UNLOCK)
                            PROG_MODE <= (unlock_reg == `TPP_UNLOCK_KEY);
                        else if (ir_reg == `TPP_IR_COMMAND)
                        begin
                            MEM_CMD       <= cmd_reg;
                            MEM_CMD_VALID <= 1'b1;
                        end
                        else if (ir_reg == `TPP_IR_PAGE_FILL)
                        begin
                            // hold byte, step before low except first
                            hold_reg      <= {high_byte_reg, cmd_reg[7:0]};
                            fill_go_reg   <= 1'b1;
                            high_byte_reg <= !high_byte_reg;
                            first_reg     <= 1'b0;
                            if (!high_byte_reg && !first_reg)
                            begin
                                PC            <= PC + 16'h0001;
                                hold_addr_reg <= PC + 16'h0001;
                            end
                            else
                                hold_addr_reg <= PC;
                        end
                    end
                    S_IDLE:
                    begin
                        if (ir_reg == `TPP_IR_COMMAND && PROG_MODE)
                            MEM_EXEC <= 1'b1; // one clock per idle cycle
                    end
                    default:
                    begin
                        ir_reg <= ir_reg;
                    end
                endcase
            end
        end
    end

    // tdo on falling TCK, driven in shift states only
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            TDO    <= 1'b0;
            TDO_OE <= 1'b0;
        end
        else if (tck_fall)
        begin
            TDO_OE <= port_ok && (state_reg == S_SH_DR || state_reg == S_SH_IR);
            if (state_reg == S_SH_IR)
                TDO <= ir_shift_reg[0];
            else if (ir_reg == `TPP_IR_RESET_CHAIN)
                TDO <= reset_chain_reg;
            else if (ir_reg == `TPP_IR_UNLOCK)
                TDO <= unlock_reg[0];
            else if (ir_reg >= `TPP_IR_COMMAND && ir_reg <= `TPP_IR_PAGE_FETCH)
                TDO <= cmd_reg[0];
            else
                TDO <= bypass_reg;
        end
    end

    // page write delay counter, finishes on the first clock that the buffer has room, waits while it is full
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            fill_cnt_reg <= 4'h0;
        else if (fill_go_reg)
            fill_cnt_reg <= 4'h1;
        else if (fill_cnt_reg != 4'h0 && fifo_ready)
            fill_cnt_reg <= 4'h0;
    end

    // disable bit: set by core, cleared after two clocks of reset low
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            disable_reg <= 1'b0;
            dis_cnt_reg <= 2'h0;
        end
        else if (!rst_s2_reg)
        begin
            if (dis_cnt_reg == 2'd`TPP_DISABLE_CLR_CLKS - 2'd1)
                disable_reg <= 1'b0;
            else
                dis_cnt_reg <= dis_cnt_reg + 2'h1;
        end
        else
        begin
            dis_cnt_reg <= 2'h0;
            if (DISABLE_SET)
                disable_reg <= 1'b1;
        end
    end

    assign DISABLE_BIT = disable_reg;
    // unlatched chain output acts as reset pin low
    assign CORE_RESET  = reset_chain_reg || !rst_s2_reg;

    // page buffer stream: {high flag, byte} with address
    tpp_fifo #(
        .WIDTH (25),
        .DEPTH (`TPP_FIFO_DEPTH),
        .AW    (`TPP_FIFO_AW)
    ) u_fifo (
        .clk       (CLK),
        .rstn      (RSTN),
        .in_valid  (fill_cnt_reg != 4'h0),
        .in_ready  (fifo_ready),
        .in_data   ({hold_addr_reg, hold_reg}),
        .out_valid (PAGE_VALID),
        .out_ready (PAGE_READY),
        .out_data  ({PAGE_ADDR, PAGE_DATA})
    );
endmodule
`default_nettype wire

// File: test/tpp_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tpp_top_assertions (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RSTN,
    // test port
    input wire logic        TCK,
    input wire logic        TDO,
    input wire logic        TDO_OE,
    // device control
    input wire logic        EXT_RESETN,
    input wire logic        DISABLE_BIT,
    input wire logic        CORE_RESET,
    input wire logic        PROG_MODE,
    // memory side and page stream
    input wire logic [14:0] MEM_CMD,
    input wire logic        MEM_CMD_VALID,
    input wire logic        MEM_EXEC,
    input wire logic        PAGE_VALID,
    input wire logic        PAGE_READY,
    input wire logic [8:0]  PAGE_DATA
);
    // every check runs on the core clock
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // pin reset and its effect on the core
    chk_pin_reset_core: assert property (!EXT_RESETN [*4] |-> CORE_RESET)
        else $error("core reset missing while pin held low");
    chk_pin_clears_disable: assert property (!EXT_RESETN [*5] |-> !DISABLE_BIT)
        else $error("disable bit survived pin reset");
    // one execute pulse per idle clock, only when unlocked
    chk_exec_single_pulse: assert property (MEM_EXEC |=> !MEM_EXEC [*7])
        else $error("execute pulse longer than one cycle");
    chk_exec_needs_unlock: assert property (MEM_EXEC |-> PROG_MODE)
        else $error("execute pulse without programming mode");
    chk_command_held: assert property (MEM_CMD_VALID |=> $stable(MEM_CMD) [*8])
        else $error("command changed right after presentation");
    // serial out moves only while the port clock is low, programming mode only while it is high
    chk_tdo_on_fall: assert property ($changed(TDO) |-> !TCK)
        else $error("tdo changed while port clock high");
    chk_oe_on_fall: assert property ($changed(TDO_OE) |-> !TCK)
        else $error("tdo enable changed while port clock high");
    chk_mode_on_update: assert property ($changed(PROG_MODE) |-> TCK)
        else $error("programming mode changed outside an update");
    // stalled page entry holds its contents
    chk_page_entry_hold: assert property (PAGE_VALID && !PAGE_READY |=>
        PAGE_VALID && $stable(PAGE_DATA))
        else $error("page entry dropped or changed while stalled");
endmodule

bind tpp_top tpp_top_assertions u_chk (
    .CLK(CLK), .RSTN(RSTN), .TCK(TCK), .TDO(TDO), .TDO_OE(TDO_OE), .EXT_RESETN(EXT_RESETN),
    .DISABLE_BIT(DISABLE_BIT), .CORE_RESET(CORE_RESET), .PROG_MODE(PROG_MODE),
    .MEM_CMD(MEM_CMD), .MEM_CMD_VALID(MEM_CMD_VALID), .MEM_EXEC(MEM_EXEC),
    .PAGE_VALID(PAGE_VALID), .PAGE_READY(PAGE_READY), .PAGE_DATA(PAGE_DATA)
);
`default_nettype wire

// File: test/tpp_programmer.sv
`timescale 1ns/1ps
`default_nettype none
module tpp_programmer #(
    parameter int LOW_CLKS  = 12,
    parameter int HIGH_CLKS = 13
) (
    // core clock, paces the port clock
    input  wire logic clk,
    // test port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // port clock parked low outside frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one 125 ns port clock, all pins moved just after a core edge; read tdo at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (LOW_CLKS) @(posedge clk);
        #1;
        tck = 1'b1;
        q = tdo;
        repeat (HIGH_CLKS) @(posedge clk);
        #1;
        tck = 1'b0;
    endtask

    // idle clocks; unused data line toggles every cycle
    task automatic idle(input int n);
        logic q;
        repeat (n) step(1'b0, ~tdi, q);
    endtask

    // park in run-test/idle from any state
    task automatic to_idle();
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        idle(1);
    endtask

    // idle to idle scan of n bits through ir or dr, then one idle clock
    task automatic scan(input logic ir, input logic [15:0] din, input int n,
                        output logic [15:0] dout);
        logic q;
        dout = 16'h0000;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        idle(1);
    endtask
endmodule
`default_nettype wire

// File: test/tpp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpp_regs.vh"
module tpp_top_tb;
    // bench state
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ext_resetn = 1'b1;
    logic        enable_fuse = 1'b1;
    logic        disable_set = 1'b0;
    logic        page_ready = 1'b0;
    logic [14:0] mem_result = 15'h0000;
    logic [15:0] mem_rdata = 16'h0000;
    logic        tck, tms, tdi, tdo, tdo_oe, disable_bit, core_reset, prog_mode;
    logic        mem_cmd_valid, mem_exec, page_valid;
    logic [14:0] mem_cmd;
    logic [15:0] pc, page_addr, got;
    logic [8:0]  page_data;
    int          errors = 0, checked = 0, n_exec = 0, n_cmd = 0, n_oe = 0;

    tpp_top u_dut (
        .CLK(clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE(tdo_oe), .EXT_RESETN(ext_resetn), .ENABLE_FUSE(enable_fuse),
        .DISABLE_SET(disable_set), .DISABLE_BIT(disable_bit), .CORE_RESET(core_reset),
        .PROG_MODE(prog_mode), .MEM_CMD(mem_cmd), .MEM_CMD_VALID(mem_cmd_valid),
        .MEM_EXEC(mem_exec), .MEM_RESULT(mem_result), .MEM_RDATA(mem_rdata), .PC(pc),
        .PAGE_VALID(page_valid), .PAGE_READY(page_ready), .PAGE_DATA(page_data),
        .PAGE_ADDR(page_addr)
    );
    // programmer sees the enable-gated line; a released line is pulled high
    tpp_programmer u_prog (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
                           .tdo(tdo_oe ? tdo : 1'b1));

    // core clock
    always #2.5 clk = ~clk;

    // memory word per address; pulses tallied at the edge
    function automatic logic [15:0] word(input logic [15:0] a);
        return {a[7:0] ^ 8'hC3, a[7:0] ^ 8'h5A};
    endfunction
    always @(posedge clk)
    begin
        n_exec += (mem_exec === 1'b1);
        n_cmd += (mem_cmd_valid === 1'b1);
        n_oe += (tdo_oe === 1'b1);
        #1;
        mem_rdata = word(pc);
    end

    task automatic complete_run();
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // helpers: step off the edge, load an instruction, scan data
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic load_ir(input logic [3:0] code);
        tick();
        u_prog.scan(1'b1, {12'h000, code}, 4, got);
        check("ir capture", got, 16'h0001);
    endtask
    task automatic dr(input logic [15:0] din, input int n);
        tick();
        u_prog.scan(1'b0, din, n, got);
        tick();
    endtask

    // undecoded code is a one-bit bypass; reset chain and pin reset
    task automatic t_bypass_chain();
        load_ir(4'hB);
        n_oe = 0;
        dr(16'h00A5, 8);
        check("bypass", got, 16'h004A);
        check("oe cycles", n_oe, 16'd200);
        check("no reset", core_reset, 1'b0);
        load_ir(`TPP_IR_RESET_CHAIN);
        dr(16'h0001, 1);
        check("chain set", core_reset, 1'b1);
        dr(16'h0000, 1);
        check("chain clear", core_reset, 1'b0);
        ext_resetn = 1'b0;
        repeat (4) tick();
        check("pin reset", core_reset, 1'b1);
        ext_resetn = 1'b1;
        u_prog.to_idle();
    endtask

    // near misses of the key, then the key itself
    task automatic t_unlock();
        logic [15:0] keys [3] = '{16'hA371, 16'h2370, `TPP_UNLOCK_KEY};
        load_ir(`TPP_IR_UNLOCK);
        foreach (keys[k])
        begin
            dr(keys[k], 16);
            check("prog mode", prog_mode, k == 2);
        end
    endtask

    // result out while the next command goes in, then idle clocks
    task automatic t_command();
        load_ir(`TPP_IR_COMMAND);
        mem_result = 15'h2B5A;
        n_exec = 0;
        n_cmd = 0;
        dr(16'h3C96, 15);
        u_prog.idle(2);
        tick();
        check("result", got, 16'h2B5A);
        check("command", mem_cmd, 15'h3C96);
        check("cmd pulses", n_cmd, 1);
        check("exec pulses", n_exec, 3);
    endtask

    // seventeen bytes into a stalled buffer, then drain one entry per clock
    task automatic t_fill();
        load_ir(`TPP_IR_PAGE_FILL);
        for (int i = 0; i < 17; i++)
        begin
            dr(16'(16 + i), 8);
            if (i == 0)
                check("entry soon", page_valid, 1'b1);
        end
        check("pc after fill", pc, 16'h0008);
        for (int i = 0; i < 17; i++)
        begin
            repeat (8) if (page_valid !== 1'b1) tick();
            check("page data", page_data, {i[0], 8'h10 + i[7:0]});
            check("page addr", page_addr, 16'(i / 2));
            page_ready = 1'b1;
            tick();
            page_ready = 1'b0;
        end
        repeat (3) tick();
        check("drained", page_valid, 1'b0);
    endtask

    // low then high byte of each word, counter steps after each high byte
    task automatic t_fetch();
        logic [15:0] w;
        load_ir(`TPP_IR_PAGE_FETCH);
        for (int k = 0; k < 4; k++)
        begin
            w = word(16'(8 + k / 2));
            dr(16'h0000, 8);
            check("fetch byte", got, k[0] ? w[15:8] : w[7:0]);
            if (k == 1)
                check("pc step", pc, 16'h0009);
        end
        check("pc after fetch", pc, 16'h000A);
        load_ir(`TPP_IR_UNLOCK);
        dr(16'h0000, 16);
        check("left prog mode", prog_mode, 1'b0);
    endtask

    // disabled or unfused port ignores the chain; pin reset frees it
    task automatic t_disable();
        disable_set = 1'b1;
        tick();
        disable_set = 1'b0;
        check("disable set", disable_bit, 1'b1);
        u_prog.to_idle();
        u_prog.scan(1'b1, {12'h000, `TPP_IR_RESET_CHAIN}, 4, got);
        dr(16'h0001, 1);
        check("locked chain", core_reset, 1'b0);
        ext_resetn = 1'b0;
        repeat (5) tick();
        check("disable cleared", disable_bit, 1'b0);
        ext_resetn = 1'b1;
        enable_fuse = 1'b0;
        u_prog.to_idle();
        u_prog.scan(1'b1, {12'h000, `TPP_IR_RESET_CHAIN}, 4, got);
        dr(16'h0001, 1);
        check("unfused chain", core_reset, 1'b0);
        enable_fuse = 1'b1;
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        rstn = 1'b1;
        check("oe idle", tdo_oe, 1'b0);
        check("pc reset", pc, 16'h0000);
        u_prog.to_idle();
        t_bypass_chain();
        t_unlock();
        t_command();
        t_fill();
        t_fetch();
        t_disable();
        complete_run();
    end

    // hang guard
    initial
    begin
        #300_000;
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
